// ### src/dsseq_pkg.sv
// Package: constants, types and state record of the dual-slope sequencer.
`default_nettype none
package dsseq_pkg;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	// Status word field positions; the reading sits in bits 14..0.
	localparam int STAT_POL = 16;
	localparam int STAT_OVER = 17;
	localparam int STAT_UNDER = 18;
	localparam int STAT_BUSY = 19;
	localparam int STAT_HELD = 20;
	// Value after reset of the count-clock divisor (one count per clk_sys).
	localparam logic [15:0] DIV_RESET = 16'h0000;
	// Long counts in converter counts; the top module turns them into parameters.
	localparam int CYCLE_LEN_DEF = 40002;
	localparam int INT_LEN_DEF = 10000;
	localparam int FULL_SCALE_DEF = 20000;
	localparam int ZI_OVER_DEF = 6200;
	// Short counts in converter counts; DIGITS is the number of display digits.
	localparam logic [14:0] UNDER_LIMIT = 15'h0708;
	localparam int ZI_NORMAL = 150;
	localparam logic [7:0] MSD_LEN = 8'hC9;
	localparam logic [7:0] DIGIT_LEN = 8'hC8;
	localparam logic [7:0] STROBE_AT = 8'h64;
	localparam logic [2:0] DIGITS = 3'h5;

	typedef enum logic [1:0] {PH_NULL, PH_INT, PH_RAMP, PH_RESET} phase_t;
	typedef logic [4:0][3:0] bcd5_t;

	// APB request from the master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// Whole state of the sequencer.
	typedef struct packed {
		phase_t      phase;
		logic        held;
		logic        startPend;
		logic        runPrev;
		logic [15:0] divisor;
		logic [15:0] divCnt;
		logic [15:0] cycPos;
		logic [13:0] phCnt;
		logic        deFirst;
		logic [14:0] binCnt;
		bcd5_t       bcdCnt;
		logic [14:0] reading;
		bcd5_t       readBcd;
		logic        latchPend;
		logic        busy;
		logic        polarity;
		logic        over;
		logic        under;
		logic        convOver;
		bcd5_t       dispBcd;
		logic [2:0]  digSel;
		logic [7:0]  digCnt;
		logic        msdLong;
		logic [2:0]  strobesLeft;
		logic        seqEnd;
		logic        blank;
		logic        lastOver;
		logic        strobeN;
		logic [15:0] stLeft;
		logic [4:0]  digitDrive;
		logic [3:0]  bcd;
	} state_t;
endpackage
`default_nettype wire

// ### src/dual_slope_sequencer.sv
// Dual-slope converter sequencer with multiplexed BCD output and APB registers.
`default_nettype none
module dual_slope_sequencer
	import dsseq_pkg::*;
#(
	parameter int CYCLE_LEN  = CYCLE_LEN_DEF,
	parameter int INT_LEN    = INT_LEN_DEF,
	parameter int FULL_SCALE = FULL_SCALE_DEF,
	parameter int ZI_OVER    = ZI_OVER_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire apb_req_t    apb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        runHold,
	input  wire logic        integratorPositive,
	input  wire logic        zeroCross,
	output logic             offsetNullPhase,
	output logic             integratePhase,
	output logic             referenceRampPhase,
	output logic             integratorResetPhase,
	output logic             busy,
	output logic             strobeN,
	output logic             overrange,
	output logic             underrange,
	output logic             polarity,
	output logic [4:0]       digitDrive,
	output logic [3:0]       bcd
);
	state_t st;
	state_t next_st;
	logic   tick;
	logic   endCycle;
	logic   runRise;
	logic   apbAcc;
	logic   apbHit;

	// Add one to a five-digit BCD value, rippling the carry upward.
	function automatic bcd5_t bcdInc(input bcd5_t v);
		bcd5_t r;
		logic  c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (c) begin
				if (r[i] == 4'h9) begin
					r[i] = 4'h0;
				end else begin
					r[i] = r[i] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Count enable from the divisor; every phase length is measured in these counts.
	// A divisor written below the running count must not stall for a full wrap.
	assign tick = (st.divCnt >= st.divisor);
	assign endCycle = tick && st.phase == PH_NULL && !st.held
		&& st.cycPos == 16'(CYCLE_LEN - 1);
	assign runRise = runHold && !st.runPrev;
	assign apbAcc = apb.psel && apb.penable;
	assign apbHit = apb.paddr == CTRL_ADDR || apb.paddr == STAT_ADDR;

	// Zero-wait slave; reads come straight from the state flops.
	always_comb begin
		prdata = 32'h0000_0000;
		if (apb.paddr == CTRL_ADDR) begin
			prdata[15:0] = st.divisor;
		end else if (apb.paddr == STAT_ADDR) begin
			prdata[14:0] = st.reading;
			prdata[STAT_POL] = st.polarity;
			prdata[STAT_OVER] = st.over;
			prdata[STAT_UNDER] = st.under;
			prdata[STAT_BUSY] = st.busy;
			prdata[STAT_HELD] = st.held;
		end
	end
	assign pready = 1'b1;
	assign pslverr = apbAcc && !apbHit;

	// Next-state logic for the whole sequencer.
	always_comb begin
		logic goInt;
		logic [7:0] lastCnt;
		logic [7:0] strobeCnt;
		logic atFull;
		goInt = 1'b0;
		lastCnt = 8'h00;
		// The long top digit centres its strobe one count later than the others.
		strobeCnt = st.msdLong ? STROBE_AT : STROBE_AT - 8'h01;
		atFull = !st.deFirst && st.binCnt == 15'(FULL_SCALE);
		next_st = st;
		next_st.runPrev = runHold;
		next_st.divCnt = tick ? 16'h0000 : st.divCnt + 16'h0001;
		if (apbAcc && apb.pwrite && apb.paddr == CTRL_ADDR) begin
			next_st.divisor = apb.pwdata[15:0];
		end
		// Only a holding converter listens for a start pulse.
		if (st.held && runRise) begin
			next_st.startPend = 1'b1;
		end
		// Strobe stays low for about half a count period.
		if (!st.strobeN) begin
			if (st.stLeft == 16'h0000) begin
				next_st.strobeN = 1'b1;
			end else begin
				next_st.stLeft = st.stLeft - 16'h0001;
			end
		end
		if (tick) begin
			// Output latches load during the count after busy fell.
			if (st.latchPend) begin
				next_st.latchPend = 1'b0;
				next_st.reading = st.binCnt;
				next_st.readBcd = st.bcdCnt;
				next_st.over = st.convOver;
				next_st.under = !st.convOver && st.binCnt <= UNDER_LIMIT;
			end
			case (st.phase)
				PH_NULL: begin
					if (st.held) begin
						goInt = runHold || st.startPend;
					end else if (endCycle) begin
						goInt = runHold;
						next_st.held = !runHold;
					end else begin
						next_st.cycPos = st.cycPos + 16'h0001;
					end
				end
				PH_INT: begin
					next_st.cycPos = st.cycPos + 16'h0001;
					next_st.phCnt = st.phCnt + 14'h0001;
					if (st.phCnt == 14'(INT_LEN - 1)) begin
						next_st.phase = PH_RAMP;
						next_st.polarity = integratorPositive;
						next_st.over = 1'b0;
						next_st.deFirst = 1'b1;
						next_st.binCnt = 15'h0000;
						next_st.bcdCnt = '0;
						// A blanked display restarts its scan here.
						if (st.blank) begin
							next_st.blank = 1'b0;
							next_st.digSel = 3'h0;
							next_st.digCnt = 8'h00;
							next_st.msdLong = 1'b0;
						end
					end
				end
				PH_RAMP: begin
					next_st.cycPos = st.cycPos + 16'h0001;
					// Zero crossing arrives already flopped, so the first count is dropped.
					if (zeroCross || atFull) begin
						next_st.phase = PH_RESET;
						next_st.busy = 1'b0;
						next_st.latchPend = 1'b1;
						next_st.convOver = atFull;
						next_st.phCnt = 14'h0000;
						// The count that sees the crossing still counts, so the ramp phase spans
						// exactly one uncounted count besides the reading.
						if (!atFull && !st.deFirst) begin
							next_st.binCnt = st.binCnt + 15'h0001;
							next_st.bcdCnt = bcdInc(st.bcdCnt);
						end
					end else if (st.deFirst) begin
						next_st.deFirst = 1'b0;
					end else begin
						next_st.binCnt = st.binCnt + 15'h0001;
						next_st.bcdCnt = bcdInc(st.bcdCnt);
					end
				end
				PH_RESET: begin
					next_st.cycPos = st.cycPos + 16'h0001;
					next_st.phCnt = st.phCnt + 14'h0001;
					if (st.phCnt == 14'((st.convOver ? ZI_OVER : ZI_NORMAL) - 1)) begin
						next_st.phase = PH_NULL;
					end
				end
				default: begin
					next_st.phase = PH_NULL;
				end
			endcase
			if (goInt) begin
				next_st.phase = PH_INT;
				next_st.cycPos = 16'h0000;
				next_st.phCnt = 14'h0000;
				next_st.held = 1'b0;
				next_st.startPend = 1'b0;
				next_st.busy = 1'b1;
				next_st.under = 1'b0;
			end
			// Digit scan: one drive at a time, strobe in the middle of each of the first five digits after a cycle ends.
			if (!st.blank) begin
				lastCnt = st.msdLong ? MSD_LEN - 8'h01 : DIGIT_LEN - 8'h01;
				if (st.digCnt == strobeCnt && st.strobesLeft != 3'h0) begin
					next_st.strobeN = 1'b0;
					next_st.stLeft = {1'b0, st.divisor[15:1]};
					next_st.strobesLeft = st.strobesLeft - 3'h1;
					next_st.seqEnd = st.strobesLeft == 3'h1;
				end
				if (st.digCnt == lastCnt) begin
					next_st.digCnt = 8'h00;
					next_st.msdLong = 1'b0;
					next_st.digSel = (st.digSel == DIGITS - 3'h1) ? 3'h0 : st.digSel + 3'h1;
					if (st.digSel == DIGITS - 3'h1) begin
						next_st.seqEnd = 1'b0;
						next_st.blank = st.seqEnd && st.lastOver;
					end
				end else begin
					next_st.digCnt = st.digCnt + 8'h01;
				end
			end
			// A finished cycle reloads the display and arms five strobes.
			if (endCycle) begin
				next_st.dispBcd = st.readBcd;
				next_st.lastOver = st.over;
				next_st.digSel = 3'h0;
				next_st.digCnt = 8'h00;
				next_st.msdLong = 1'b1;
				next_st.strobesLeft = DIGITS;
				next_st.seqEnd = 1'b0;
				next_st.blank = 1'b0;
			end
		end
		// Drive and digit code change in the same flop update.
		next_st.digitDrive = next_st.blank ? 5'h00 : 5'h10 >> next_st.digSel;
		next_st.bcd = next_st.blank ? 4'h0 : next_st.dispBcd[DIGITS - 3'h1 - next_st.digSel];
	end

	// State register; reset holds the converter with a blank display.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st <= '0;
			st.divisor <= DIV_RESET;
			st.held <= 1'b1;
			st.blank <= 1'b1;
			st.strobeN <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Pin outputs; the phase pins decode a single state field.
	assign offsetNullPhase = st.phase == PH_NULL;
	assign integratePhase = st.phase == PH_INT;
	assign referenceRampPhase = st.phase == PH_RAMP;
	assign integratorResetPhase = st.phase == PH_RESET;
	assign busy = st.busy;
	assign strobeN = st.strobeN;
	assign overrange = st.over;
	assign underrange = st.under;
	assign polarity = st.polarity;
	assign digitDrive = st.digitDrive;
	assign bcd = st.bcd;

	// Helper counters that only the checks below read.
	logic [13:0] ziTicks;
	logic [2:0]  strobeTotal;
	always_ff @(posedge clk_sys) begin
		if (reset || !integratorResetPhase) begin
			ziTicks <= 14'h0000;
		end else begin
			ziTicks <= ziTicks + {13'h0000, tick};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset || endCycle) begin
			strobeTotal <= 3'h0;
		end else if (!strobeN && $past(strobeN)) begin
			strobeTotal <= strobeTotal + 3'h1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_busy_low_phase;
		!busy |-> (offsetNullPhase || integratorResetPhase);
	endproperty
	a_busy_low_phase: assert property (p_busy_low_phase)
		else $error("busy low outside reset or null phase");

	property p_ramp_after_int;
		$rose(referenceRampPhase) |-> $past(integratePhase);
	endproperty
	a_ramp_after_int: assert property (p_ramp_after_int)
		else $error("ramp did not follow accumulation");

	property p_reset_after_ramp;
		$rose(integratorResetPhase) |-> $past(referenceRampPhase) && $fell(busy);
	endproperty
	a_reset_after_ramp: assert property (p_reset_after_ramp)
		else $error("reset phase without ramp end and busy fall");

	property p_busy_rise;
		$rose(integratePhase) |-> $rose(busy) && !underrange;
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("accumulation start without busy or underrange clear");

	property p_pol_capture;
		$rose(referenceRampPhase) |-> polarity == $past(integratorPositive) && !overrange;
	endproperty
	a_pol_capture: assert property (p_pol_capture)
		else $error("polarity or overrange wrong at ramp start");

	property p_zi_len;
		$fell(integratorResetPhase) |->
			(ziTicks == 14'(ZI_NORMAL) || ziTicks == 14'(ZI_OVER));
	endproperty
	a_zi_len: assert property (p_zi_len)
		else $error("integrator reset phase has wrong length");

	property p_strobe_mid;
		$fell(strobeN) |-> $stable(digitDrive) && $stable(bcd) && digitDrive != 5'h00;
	endproperty
	a_strobe_mid: assert property (p_strobe_mid)
		else $error("strobe not inside a steady digit");

	property p_strobe_count;
		strobeTotal <= 3'h5;
	endproperty
	a_strobe_count: assert property (p_strobe_count)
		else $error("more than five strobes in one cycle");

	property p_msd_first;
		endCycle |=> digitDrive == 5'h10 ##1 (strobeN || digitDrive == 5'h10);
	endproperty
	a_msd_first: assert property (p_msd_first)
		else $error("scan did not start at the top digit");

	property p_pulse_ignored;
		(!st.held && !st.startPend && runRise) |=> !st.startPend;
	endproperty
	a_pulse_ignored: assert property (p_pulse_ignored)
		else $error("start pulse taken while not holding");

	property p_latch_load;
		st.latchPend && tick |=> st.reading == $past(st.binCnt) && !st.latchPend;
	endproperty
	a_latch_load: assert property (p_latch_load)
		else $error("reading not loaded one count after busy fell");

	property p_blank_dark;
		st.blank |-> digitDrive == 5'h00 && bcd == 4'h0;
	endproperty
	a_blank_dark: assert property (p_blank_dark)
		else $error("digit drive or code active while blanked");

	c_overrange: cover property ($rose(overrange));
	c_underrange: cover property ($rose(underrange));
	c_hold_start: cover property (st.held && st.startPend);
	c_strobe: cover property ($fell(strobeN));
endmodule
`default_nettype wire

// ### tb/adc_front_model.sv
// Behavioural analog front end: integrator sign and comparator zero crossing.
`default_nettype none
module adc_front_model (
	input  wire logic        clk_sys,
	input  wire logic        referenceRampPhase,
	input  wire logic [15:0] target,
	input  wire logic        signPos,
	output logic             integratorPositive,
	output logic             zeroCross
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rampCnt;
	// The integrator is back at zero after target ramp counts; the flopped crossing
	// is seen on the next count, and a target above full scale never crosses.
	always_ff @(posedge clk_sys) begin
		rampCnt <= referenceRampPhase ? rampCnt + 16'h0001 : 16'h0000;
		zeroCross <= referenceRampPhase
			&& ({1'b0, rampCnt} + 17'h00001 >= {1'b0, target});
	end
	// The sign of the input stays put for the whole measurement.
	assign integratorPositive = signPos;
endmodule
`default_nettype wire

// ### tb/dual_slope_sequencer_bcd_output_tb.sv
// Self-checking bench for the dual-slope sequencer and its front end model.
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %0d got %0d", nm, (e), (g)); end end
module dual_slope_sequencer_bcd_output_tb
	import dsseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset, runHold, signPos, integratorPositive, zeroCross;
	logic offsetNullPhase, integratePhase, referenceRampPhase, integratorResetPhase;
	logic busy, strobeN, overrange, underrange, polarity, pready, pslverr;
	logic pBusy, pInt, pZ, pMsd;
	logic [1:0]  ph, pPh;
	logic [4:0]  digitDrive;
	logic [3:0]  bcd;
	logic [31:0] prdata;
	logic [15:0] target;
	apb_req_t    apb;
	logic [4:0]  sDrv [5];
	logic [3:0]  sBcd [5];
	int          tStb [5];
	int total_checks, miscompares, cyc, busyLen, zLen, msdLen, tMsd, nStb, nInt, tInt, per;

	dual_slope_sequencer #(.CYCLE_LEN(400), .INT_LEN(100), .FULL_SCALE(200), .ZI_OVER(62))
		dual_slope_sequencer_i (.clk_sys(clk_sys), .reset(reset), .apb(apb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .runHold(runHold),
		.integratorPositive(integratorPositive), .zeroCross(zeroCross),
		.offsetNullPhase(offsetNullPhase), .integratePhase(integratePhase),
		.referenceRampPhase(referenceRampPhase), .integratorResetPhase(integratorResetPhase),
		.busy(busy), .strobeN(strobeN), .overrange(overrange), .underrange(underrange),
		.polarity(polarity), .digitDrive(digitDrive), .bcd(bcd));
	adc_front_model adc_front_model_i (.clk_sys(clk_sys), .target(target),
		.referenceRampPhase(referenceRampPhase), .signPos(signPos),
		.integratorPositive(integratorPositive), .zeroCross(zeroCross));

	// Phase code: null 0, accumulate 1, ramp 2, reset 3.
	assign ph = {referenceRampPhase | integratorResetPhase, integratePhase | integratorResetPhase};

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic complete_run;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Monitor samples pre-edge values, so lengths are counted in whole clocks.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			miscompares++;
			complete_run();
		end
		if (busy && !pBusy) busyLen = 0;
		if (busy) busyLen++;
		if (integratorResetPhase && !pZ) zLen = 0;
		if (integratorResetPhase) zLen++;
		if (digitDrive[4] && !pMsd) begin
			msdLen = 0;
			tMsd = cyc;
		end
		if (digitDrive[4]) msdLen++;
		if (integratePhase && !pInt) begin
			nInt++;
			per = cyc - tInt;
			tInt = cyc;
		end
		if (!strobeN && nStb < 5) begin
			sDrv[nStb] = digitDrive;
			sBcd[nStb] = bcd;
			tStb[nStb] = cyc;
		end
		if (!strobeN) nStb++;
		if (!reset && !busy) `CHK("idlePhase", 1'b0, integratePhase | referenceRampPhase)
		if (!reset && ph != pPh) `CHK("phaseOrder", pPh + 2'h1, ph)
		pPh = reset ? 2'h0 : ph;
		{pBusy, pInt, pZ, pMsd} = {busy, integratePhase, integratorResetPhase, digitDrive[4]};
	end

	// One APB transfer; the idle cycle after it keeps each signal to one update a step.
	task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		apb.penable <= 1'b1;
		// The wait ends when pready is high; it has no limit of its own, so only the bench timeout ends a hang.
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		apb <= '0;
		@(posedge clk_sys);
	endtask

	// Reset values, divisor storage, read-only status and an unmapped address.
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		apbXfer(1'b0, STAT_ADDR, 32'h0, r, e);
		`CHK("status", 32'h00100000, r)
		apbXfer(1'b0, CTRL_ADDR, 32'h0, r, e);
		`CHK("divisor", {16'h0000, DIV_RESET}, r)
		apbXfer(1'b1, CTRL_ADDR, 32'h00000003, r, e);
		apbXfer(1'b0, CTRL_ADDR, 32'h0, r, e);
		`CHK("divisorRw", 32'h00000003, r)
		apbXfer(1'b1, CTRL_ADDR, 32'h0, r, e);
		apbXfer(1'b1, STAT_ADDR, 32'hFFFFFFFF, r, e);
		apbXfer(1'b0, 8'h0C, 32'h0, r, e);
		`CHK("unmappedErr", 1'b1, e)
		`CHK("unmappedData", 32'h0, r)
		apbXfer(1'b0, STAT_ADDR, 32'h0, r, e);
		`CHK("statusRo", 32'h00100000, r)
	endtask

	// Held conversion: start pulse, a stray pulse mid-cycle, then flags and strobes.
	task automatic t_conv(input logic [15:0] t, input logic s, input logic ov);
		logic [31:0] r;
		logic e;
		int n, k, rd;
		target <= t;
		signPos <= s;
		nStb = 0;
		repeat (110) @(posedge clk_sys);
		runHold <= 1'b1;
		n = 0;
		k = nInt;
		while (nInt == k && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK("nullLen", 1'b1, n >= 1 && n < 20)
		repeat (31) @(posedge clk_sys);
		runHold <= 1'b0;
		repeat (30) @(posedge clk_sys);
		runHold <= 1'b1;
		repeat (31) @(posedge clk_sys);
		runHold <= 1'b0;
		n = 0;
		while (nStb < 5 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		apbXfer(1'b0, STAT_ADDR, 32'h0, r, e);
		rd = int'(r[14:0]);
		`CHK("starts", k + 1, nInt)
		`CHK("over", ov, overrange)
		`CHK("under", !ov, underrange)
		`CHK("polarity", s, polarity)
		`CHK("resetLen", ov ? 62 : 150, zLen)
		`CHK("msdLen", 201, msdLen)
		`CHK("firstStrobe", 101, tStb[0] - tMsd)
		for (int i = 0; i < 5; i++) begin
			`CHK("drive", 5'h10 >> i, sDrv[i])
			if (i > 0) `CHK("gap", 200, tStb[i] - tStb[i - 1])
			if (!ov) `CHK("bcd", 4'(rd / 10 ** (4 - i) % 10), sBcd[i])
		end
		if (!ov) begin
			`CHK("reading", 1'b1, rd >= t - 1 && rd <= t + 1)
			`CHK("busyLen", 101 + rd, busyLen)
		end
		repeat (1200) @(posedge clk_sys);
		`CHK("strobes", 5, nStb)
		`CHK("scan", !ov, |digitDrive)
	endtask

	// Free run spaces starts evenly; a low level then holds after the current cycle.
	task automatic t_free;
		int n;
		target <= 16'h0040;
		runHold <= 1'b1;
		repeat (1300) @(posedge clk_sys);
		`CHK("period", 400, per)
		runHold <= 1'b0;
		repeat (500) @(posedge clk_sys);
		n = nInt;
		repeat (900) @(posedge clk_sys);
		`CHK("hold", n, nInt)
	endtask

	initial begin
		reset = 1'b1;
		apb = '0;
		runHold = 1'b0;
		target = 16'h0032;
		signPos = 1'b1;
		{pBusy, pInt, pZ, pMsd, pPh} = '0;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_conv(16'h0032, 1'b1, 1'b0);
		t_conv(16'hFFFF, 1'b1, 1'b1);
		t_conv(16'h007B, 1'b0, 1'b0);
		t_free();
		complete_run();
	end
endmodule
`default_nettype wire
